// >>> src/tmr2_defs.vh
// Register offsets, field positions and timing constants of the timer 2 block
`ifndef TMR2_DEFS_VH
`define TMR2_DEFS_VH
// Register byte addresses (word aligned, index times four)
`define TMR2_IDX_CONTROL      8'hc8
`define TMR2_IDX_MODE         8'hc9
`define TMR2_IDX_RELOAD_LOW   8'hca
`define TMR2_IDX_RELOAD_HIGH  8'hcb
`define TMR2_IDX_COUNT_LOW    8'hcc
`define TMR2_IDX_COUNT_HIGH   8'hcd
`define TMR2_ADDR_CONTROL     12'h320
`define TMR2_ADDR_MODE        12'h324
`define TMR2_ADDR_RELOAD_LOW  12'h328
`define TMR2_ADDR_RELOAD_HIGH 12'h32c
`define TMR2_ADDR_COUNT_LOW   12'h330
`define TMR2_ADDR_COUNT_HIGH  12'h334
// Control register fields
`define TMR2_CTL_OVERFLOW     7
`define TMR2_CTL_EXTERNAL     6
`define TMR2_CTL_RX_CLK_SEL   5
`define TMR2_CTL_TX_CLK_SEL   4
`define TMR2_CTL_EXT_ENABLE   3
`define TMR2_CTL_RUN          2
`define TMR2_CTL_COUNTER_SEL  1
`define TMR2_CTL_CAPTURE_SEL  0
// Mode register fields
`define TMR2_MOD_CLK_OUT_EN   1
`define TMR2_MOD_DOWN_EN      0
`define TMR2_MOD_MASK         8'h03
// Reset value and count top
`define TMR2_RESET_BYTE       8'h00
`define TMR2_COUNT_TOP        16'hffff
// Prescale divisors in system clocks
`define TMR2_DIV_12T          4'd12
`define TMR2_DIV_6T           4'd6
`define TMR2_DIV_BAUD         4'd2
`endif

// >>> src/tmr2_edge_sync.v
// Two-flop synchroniser with falling edge detector
`timescale 1ns/1ps
`default_nettype none
module tmr2_edge_sync (
   // Clock and reset
   input  wire pclk,
   input  wire presetn,
   // Asynchronous input and results
   input  wire pin_in,
   output reg  level,
   output wire fall
);
   reg meta;
   reg prev;

   // First flop feeds only the second one
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta  <= 1'b1;
         level <= 1'b1;
         prev  <= 1'b1;
      end else begin
         meta  <= pin_in;
         level <= meta;
         prev  <= level;
      end
   end

   // One-cycle pulse on a high-to-low step
   assign fall = prev & ~level;
endmodule // tmr2_edge_sync
`default_nettype wire

// >>> src/tmr2_timer.v
// Timer 2: 16-bit capture / auto-reload / baud generator with APB registers
//
// Summary of operation
// - Clock output enable toggles clock_output_pin on every count overflow.
// - Run, clock selects and capture select choose reload, capture, baud or off.
// - Capture mode counts 16 bits and sets overflow flag on every overflow.
// - Capture mode with external enable copies count into reload on trigger fall.
// - Trigger fall in capture sets external flag; both flags OR into one request.
// - Auto-reload counts up; with down enable, trigger high up, low down.
// - Up-count past ffff sets overflow flag and loads reload value.
// - Up-only reload mode with external enable reloads and flags on trigger fall.
// - Down-count underflows at reload value, sets overflow flag, loads ffff.
// - With down enable, external flag toggles on each wrap, no interrupt.
// - Transmit and receive clock selects pick this timer as baud sources.
// - Baud mode overflow reloads count but never sets overflow flag.
// - Baud mode trigger fall sets external flag but causes no reload.
// - Serial baud in variable modes is overflow rate divided by sixteen.
// - Baud timer rate is clock over n times (65536 minus reload).
// - Outside baud mode the timer ticks once per machine cycle, 1/6 or 1/12.
// - Baud mode timer ticks at half the system clock.
// - Timer/counter select 1 counts falling edges on the external count input.
// - Run starts counting; clearing it holds the count.
`timescale 1ns/1ps
`default_nettype none
`include "tmr2_defs.vh"
module tmr2_timer (
   // APB slave
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   input  wire [3:0]  pstrb,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   // Device pins
   input  wire        external_count_input,
   input  wire        trigger_input,
   output reg         clock_output_pin,
   // Strap: 1 selects 6-clock machine cycle, 0 the 12-clock cycle
   input  wire        six_clock_mode,
   // Serial port side
   input  wire        other_timer_overflow,
   output wire        tx_baud_tick,
   output wire        rx_baud_tick,
   output wire        tx_baud_16,
   output wire        rx_baud_16,
   output wire        timer2_irq
);
   // Registers
   reg  [7:0]  timer2_control;
   reg  [7:0]  timer2_mode;
   reg  [15:0] reload;
   reg  [15:0] count;
   reg  [3:0]  prescale;
   reg         strap_meta;
   reg         strap_6t;
   reg  [3:0]  tx_div16;
   reg  [3:0]  rx_div16;
   reg         tx_16;
   reg         rx_16;

   wire overflow_flag         = timer2_control[`TMR2_CTL_OVERFLOW];
   wire external_flag         = timer2_control[`TMR2_CTL_EXTERNAL];
   wire receive_clock_select  = timer2_control[`TMR2_CTL_RX_CLK_SEL];
   wire transmit_clock_select = timer2_control[`TMR2_CTL_TX_CLK_SEL];
   wire external_enable       = timer2_control[`TMR2_CTL_EXT_ENABLE];
   wire run_bit               = timer2_control[`TMR2_CTL_RUN];
   wire timer_counter_select  = timer2_control[`TMR2_CTL_COUNTER_SEL];
   wire capture_reload_select = timer2_control[`TMR2_CTL_CAPTURE_SEL];
   wire clock_out_enable      = timer2_mode[`TMR2_MOD_CLK_OUT_EN];
   wire down_count_enable     = timer2_mode[`TMR2_MOD_DOWN_EN];

   // Synchronised pins
   wire trig_level;
   wire trig_fall;
   wire ext_fall;

   tmr2_edge_sync u_trig_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .pin_in  (trigger_input),
      .level   (trig_level),
      .fall    (trig_fall)
   );

   tmr2_edge_sync u_count_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .pin_in  (external_count_input),
      .level   (),
      .fall    (ext_fall)
   );

   // Mode decode
   wire baud_mode    = transmit_clock_select | receive_clock_select;
   wire capture_mode = ~baud_mode & capture_reload_select;
   wire reload_mode  = ~baud_mode & ~capture_reload_select;
   wire up_down      = reload_mode & down_count_enable;
   wire count_up     = ~up_down | trig_level;

   // Prescaler: machine cycle outside baud mode, half clock in it
   wire [3:0] div_sel = baud_mode ? `TMR2_DIV_BAUD :
                        (strap_6t ? `TMR2_DIV_6T : `TMR2_DIV_12T);
   wire       pre_tick = (prescale >= div_sel - 4'd1);

   // Strap is a pin, so it passes two flops before the divider reads it
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strap_meta <= 1'b0;
         strap_6t   <= 1'b0;
         prescale   <= 4'h0;
      end else begin
         strap_meta <= six_clock_mode;
         strap_6t   <= strap_meta;
         if (!run_bit || pre_tick)
            prescale <= 4'h0;
         else
            prescale <= prescale + 4'd1;
      end
   end

   // Count step source: internal timing or external falling edges
   wire step = run_bit & (timer_counter_select ? ext_fall : pre_tick);

   wire at_top    = (count == `TMR2_COUNT_TOP);
   wire at_bottom = (count == reload);
   wire wrap_up   = step & count_up & at_top;
   wire wrap_dn   = step & ~count_up & at_bottom;
   wire wrap      = wrap_up | wrap_dn;

   // Trigger edge events, ignored while stopped
   wire trig_evt   = run_bit & external_enable & trig_fall;
   wire capture_ev = trig_evt & capture_mode;
   wire reload_ev  = trig_evt & reload_mode & ~down_count_enable;
   wire extflag_ev = trig_evt & ~up_down;

   // APB decode; zero wait states
   wire       acc      = psel & penable;
   wire       wr       = acc & pwrite & pstrb[0];
   wire       hit_ctl  = (paddr == `TMR2_ADDR_CONTROL);
   wire       hit_mod  = (paddr == `TMR2_ADDR_MODE);
   wire       hit_rl   = (paddr == `TMR2_ADDR_RELOAD_LOW);
   wire       hit_rh   = (paddr == `TMR2_ADDR_RELOAD_HIGH);
   wire       hit_cl   = (paddr == `TMR2_ADDR_COUNT_LOW);
   wire       hit_ch   = (paddr == `TMR2_ADDR_COUNT_HIGH);
   wire       mapped   = hit_ctl | hit_mod | hit_rl | hit_rh | hit_cl | hit_ch;
   wire [7:0] wbyte    = pwdata[7:0];

   assign pready  = 1'b1;
   assign pslverr = acc & ~mapped;

   // Control register with hardware-set flags; set beats software clear
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer2_control <= `TMR2_RESET_BYTE;
      end else begin
         if (wr && hit_ctl)
            timer2_control <= wbyte;
         if (wrap && !baud_mode)
            timer2_control[`TMR2_CTL_OVERFLOW] <= 1'b1;
         if (extflag_ev)
            timer2_control[`TMR2_CTL_EXTERNAL] <= 1'b1;
         else if (up_down && wrap)
            timer2_control[`TMR2_CTL_EXTERNAL] <= ~external_flag;
      end
   end

   // Mode register, two live bits
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         timer2_mode <= `TMR2_RESET_BYTE;
      else if (wr && hit_mod)
         timer2_mode <= wbyte & `TMR2_MOD_MASK;
   end

   // Reload / capture register; capture wins over a same-cycle write
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reload <= {`TMR2_RESET_BYTE, `TMR2_RESET_BYTE};
      end else if (capture_ev) begin
         reload <= count;
      end else begin
         if (wr && hit_rl)
            reload[7:0] <= wbyte;
         if (wr && hit_rh)
            reload[15:8] <= wbyte;
      end
   end

   // Counter; hardware reload or step beats software write
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= {`TMR2_RESET_BYTE, `TMR2_RESET_BYTE};
      end else if (reload_ev) begin
         count <= reload;
      end else if (wrap_up) begin
         count <= capture_mode ? 16'h0000 : reload;
      end else if (wrap_dn) begin
         count <= `TMR2_COUNT_TOP;
      end else if (step) begin
         count <= count_up ? count + 16'd1 : count - 16'd1;
      end else begin
         if (wr && hit_cl)
            count[7:0] <= wbyte;
         if (wr && hit_ch)
            count[15:8] <= wbyte;
      end
   end

   // Clock output toggles on every wrap while enabled
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         clock_output_pin <= 1'b0;
      else if (clock_out_enable && wrap)
         clock_output_pin <= ~clock_output_pin;
   end

   // Baud sources: this timer's wrap or the other timer's overflow
   assign tx_baud_tick = transmit_clock_select ? (wrap & baud_mode) : other_timer_overflow;
   assign rx_baud_tick = receive_clock_select ? (wrap & baud_mode) : other_timer_overflow;

   // Divide by sixteen for the serial port's variable-rate modes
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_div16 <= 4'h0;
         rx_div16 <= 4'h0;
         tx_16    <= 1'b0;
         rx_16    <= 1'b0;
      end else begin
         tx_16 <= tx_baud_tick & (tx_div16 == 4'hf);
         rx_16 <= rx_baud_tick & (rx_div16 == 4'hf);
         if (tx_baud_tick)
            tx_div16 <= tx_div16 + 4'd1;
         if (rx_baud_tick)
            rx_div16 <= rx_div16 + 4'd1;
      end
   end
   assign tx_baud_16 = tx_16;
   assign rx_baud_16 = rx_16;

   // Single request; external flag is silent in up/down mode
   assign timer2_irq = overflow_flag | (external_flag & ~up_down);

   // Read mux, upper bits zero
   always @* begin
      prdata = 32'h0000_0000;
      if (acc && !pwrite) begin
         if (hit_ctl)
            prdata = {24'h000000, timer2_control};
         else if (hit_mod)
            prdata = {24'h000000, timer2_mode};
         else if (hit_rl)
            prdata = {24'h000000, reload[7:0]};
         else if (hit_rh)
            prdata = {24'h000000, reload[15:8]};
         else if (hit_cl)
            prdata = {24'h000000, count[7:0]};
         else if (hit_ch)
            prdata = {24'h000000, count[15:8]};
      end
   end
endmodule // tmr2_timer
`default_nettype wire

// >>> verif/test_timer2_capture_reload_baud.sv
// Self-checking bench of the timer 2 block
`timescale 1ns/1ps
`default_nettype none
`include "tmr2_defs.vh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
   $display("ERROR %0t got %h exp %h", $time, g, e); end end
module test_timer2_capture_reload_baud;
   localparam logic [11:0] adr [6] = '{`TMR2_ADDR_CONTROL, `TMR2_ADDR_MODE,
      `TMR2_ADDR_RELOAD_LOW, `TMR2_ADDR_RELOAD_HIGH, `TMR2_ADDR_COUNT_LOW, `TMR2_ADDR_COUNT_HIGH};
   logic        pclk, presetn, psel, penable, pwrite, trig, ext_in, six, oto;
   logic        pready, pslverr, rerr, pin, txt, rxt, tx16, rx16, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rq, seed;
   logic [15:0] t16, flips, r;
   logic [7:0]  b;
   int          mismatches, tests_run, d0, d1, e;
   tmr2_timer i_tmr2_timer (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pstrb(4'hf), .prdata, .pready, .pslverr, .external_count_input(ext_in),
      .trigger_input(trig), .clock_output_pin(pin), .six_clock_mode(six),
      .other_timer_overflow(oto), .tx_baud_tick(txt), .rx_baud_tick(rxt),
      .tx_baud_16(tx16), .rx_baud_16(rx16), .timer2_irq(irq));
   tmr2_far_side i_tmr2_far_side (.pclk, .presetn, .tx_baud_16(tx16),
      .clock_output_pin(pin), .other_timer_overflow(oto), .tx16_count(t16), .pin_flips(flips));
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Wraps in a span of clocks when the count steps every second clock
   function automatic int wraps(int clks, logic [15:0] rl);
      return clks / (2 * (65536 - rl));
   endfunction
   // One APB transfer, held until pready is seen at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rq      = prdata;
      rerr    = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input int i, input logic [7:0] d); apb(1'b1, adr[i], d); endtask
   task automatic rd(input int i); apb(1'b0, adr[i], 8'h00); endtask
   task automatic set16(input int i, input logic [15:0] v);
      wr(i, v[7:0]);
      wr(i + 1, v[15:8]);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   // Count pin wanders at random so its synchroniser sees traffic
   always @(posedge pclk) ext_in <= ^xs();
   // Hang guard, far beyond the thousand or so clocks needed
   initial begin
      #40000;
      mismatches++;
      tally_and_finish();
   end
   initial begin
      {presetn, psel, penable, pwrite, six} = '0;
      {paddr, pwdata, trig, ext_in} = {44'h0, 2'b10};
      seed = 32'h1263;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         rd(i);
         `CHK(rq, 32'h0)
      end
      apb(1'b0, 12'h000, 8'h00);
      `CHK(rerr, 1'b1)
      $display("test reset done");
      for (int i = 1; i < 6; i++) begin
         b = 8'(xs());
         wr(i, b);
         rd(i);
         `CHK(rq[7:0], i == 1 ? b & `TMR2_MOD_MASK : b)
      end
      $display("test access done");
      // Up count from just below the top, twelve clocks a step
      wr(1, 8'h00);
      r = {8'(xs()), 8'h00};
      set16(2, r);
      set16(4, 16'hfffe);
      wr(0, 8'h04);
      repeat (40) @(posedge pclk);
      rd(0);
      `CHK(rq[7:0], 8'h84)
      `CHK(irq, 1'b1)
      wr(0, 8'h00);
      rd(5);
      `CHK(rq[7:0], r[15:8])
      $display("test reload done");
      six <= 1'b1;
      set16(4, 16'h1234);
      wr(0, 8'h0d);
      trig <= 1'b0;
      repeat (20) @(posedge pclk);
      rd(0);
      `CHK(rq[7:0], 8'h4d)
      wr(0, 8'h00);
      trig <= 1'b1;
      rd(3);
      `CHK(rq[7:0], 8'h12)
      $display("test capture done");
      six <= 1'b0;
      wr(1, 8'h01);
      set16(2, 16'h1000);
      set16(4, 16'h1001);
      trig <= 1'b0;
      wr(0, 8'h04);
      repeat (40) @(posedge pclk);
      rd(0);
      `CHK(rq[7:0], 8'hc4)
      wr(0, 8'h40);
      #1;
      `CHK(irq, 1'b0)
      rd(5);
      `CHK(rq[7:0], 8'hff)
      wr(1, 8'h00);
      #1;
      `CHK(irq, 1'b1)
      wr(0, 8'h00);
      trig <= 1'b1;
      $display("test down done");
      // Baud source at reload fffe, two steps a wrap, clock out on
      set16(2, 16'hfffe);
      set16(4, 16'hfffe);
      wr(1, 8'h02);
      wr(0, 8'h1c);
      d0 = t16;
      d1 = flips;
      repeat (640) @(posedge pclk);
      e = wraps(640, 16'hfffe);
      `CHK(flips - d1 inside {[e - 1:e + 1]}, 1'b1)
      `CHK(t16 - d0 inside {[e / 16 - 1:e / 16 + 1]}, 1'b1)
      // Baud run without external enable: wraps must leave the flags alone
      wr(0, 8'h14);
      repeat (40) @(posedge pclk);
      rd(0);
      `CHK(rq[7:0], 8'h14)
      wr(0, 8'h1c);
      trig <= 1'b0;
      repeat (8) @(posedge pclk);
      rd(0);
      `CHK(rq[7:0], 8'h5c)
      wr(0, 8'h10);
      rd(5);
      `CHK(rq[7:0], 8'hff)
      $display("test baud done");
      tally_and_finish();
   end
endmodule // test_timer2_capture_reload_baud
`default_nettype wire

// >>> verif/tmr2_far_side.sv
// Serial side stand-in: other timer overflows and baud pulse tallies
`timescale 1ns/1ps
`default_nettype none
module tmr2_far_side (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // Timer outputs
   input  wire logic        tx_baud_16,
   input  wire logic        clock_output_pin,
   // Other timer and tallies
   output var  logic        other_timer_overflow,
   output var  logic [15:0] tx16_count,
   output var  logic [15:0] pin_flips
);
   logic [2:0] div;
   logic       pin_q;
   // Overflow pulse every eighth clock and tallies; the bench takes differences to measure rates
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div                  <= 3'h0;
         other_timer_overflow <= 1'b0;
         tx16_count           <= 16'h0;
         pin_flips            <= 16'h0;
         pin_q                <= 1'b0;
      end else begin
         div                  <= div + 3'h1;
         other_timer_overflow <= (div == 3'h7);
         tx16_count           <= tx16_count + 16'(tx_baud_16);
         pin_q                <= clock_output_pin;
         pin_flips            <= pin_flips + 16'(pin_q != clock_output_pin);
      end
   end
endmodule // tmr2_far_side
`default_nettype wire

// >>> verif/tmr2_timer_sva.sv
// Port checker of the timer 2 block
`timescale 1ns/1ps
`default_nettype none
`include "tmr2_defs.vh"
module tmr2_sva (
   // APB side
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0]  pstrb,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   // Pins and serial side
   input wire        other_timer_overflow,
   input wire        tx_baud_tick,
   input wire        rx_baud_tick,
   input wire        tx_baud_16,
   input wire        clock_output_pin,
   input wire        timer2_irq
);
   logic       wr;
   logic [7:0] ctl;
   logic       clk_en;
   logic [3:0] ticks;
   assign wr = psel && penable && pwrite && pstrb[0];
   // Software copy of control and mode; flag bits unused as hardware moves them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl    <= 8'h00;
         clk_en <= 1'b0;
         ticks  <= 4'h0;
      end else begin
         if (wr && paddr == `TMR2_ADDR_CONTROL)
            ctl <= pwdata[7:0];
         if (wr && paddr == `TMR2_ADDR_MODE)
            clk_en <= pwdata[`TMR2_MOD_CLK_OUT_EN];
         if (tx_baud_tick)
            ticks <= ticks + 4'h1;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_access; psel && penable; endsequence
   sequence s_quiet; timer2_irq && !wr; endsequence
   property p_ready; s_access |-> pready; endproperty
   property p_hole; s_access ##0 paddr == 12'h000 |-> pslverr && prdata == 32'h0; endproperty
   property p_tx_src; !ctl[4] |-> tx_baud_tick == other_timer_overflow; endproperty
   property p_rx_src; !ctl[5] |-> rx_baud_tick == other_timer_overflow; endproperty
   property p_div16; tx_baud_16 == ($past(tx_baud_tick) && ticks == 4'h0); endproperty
   property p_clk_hold; !clk_en |=> $stable(clock_output_pin); endproperty
   property p_stopped; ctl[4] && !ctl[2] |-> !tx_baud_tick; endproperty
   property p_no_ovf; ctl[4] && !ctl[3] && !timer2_irq && !wr |=> !timer2_irq; endproperty
   property p_irq_hold; s_quiet |=> timer2_irq; endproperty
   a_ready: assert property (p_ready) else $error("ready low");
   a_hole: assert property (p_hole) else $error("hole answered");
   a_tx_src: assert property (p_tx_src) else $error("tx source");
   a_rx_src: assert property (p_rx_src) else $error("rx source");
   a_div16: assert property (p_div16) else $error("tx divide");
   a_clk_hold: assert property (p_clk_hold) else $error("pin moved");
   a_stopped: assert property (p_stopped) else $error("tick while off");
   a_no_ovf: assert property (p_no_ovf) else $error("baud irq");
   a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
endmodule // tmr2_sva
bind tmr2_timer tmr2_sva i_tmr2_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .pstrb, .prdata, .pready, .pslverr, .other_timer_overflow, .tx_baud_tick,
   .rx_baud_tick, .tx_baud_16, .clock_output_pin, .timer2_irq);
`default_nettype wire
